// File: design/ftl_rx.sv
`timescale 1ns/1ps
module ftl_rx (
    // clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    // synchronised link
    input  wire logic       i_rxc_fall,
    input  wire logic       i_act,
    input  wire logic       i_rdf,
    input  wire logic       i_take,
    // results
    output logic [7:0]      o_octet,
    output logic            o_octet_valid,
    output logic            o_frame_done,
    output logic            o_frame_bad,
    output logic            o_fault
);
    logic [7:0] shreg, next_shreg;
    logic [2:0] cnt, next_cnt;
    logic       act_q, next_act_q;
    logic [7:0] octet, next_octet;
    logic       vld, next_vld, done, next_done, bad, next_bad, flt, next_flt;

    always_comb begin
        next_shreg = shreg;
        next_cnt   = cnt;
        next_act_q = i_act;
        next_octet = octet;
        next_vld   = vld & ~i_take;
        next_done  = done;
        next_bad   = bad;
        next_flt   = flt;
        if (i_act && !act_q) begin
            next_cnt  = 3'h0;
            next_done = 1'b0;
            next_bad  = 1'b0;
        end
        // msb first reassembly so the unit arrives unchanged
        if (i_act && i_rxc_fall) begin
            next_shreg = {shreg[6:0], i_rdf};
            next_cnt   = cnt + 3'h1;
            if (cnt == ftl_pkg::BIT_LAST) begin
                next_octet = {shreg[6:0], i_rdf};
                next_vld   = 1'b1;
            end
        end
        // partial octet at end of activity marks the frame malformed
        if (!i_act && act_q) begin
            next_done = 1'b1;
            next_bad  = (cnt != 3'h0);
        end
        // data line low while idle is taken as fault indication
        next_flt = !i_act && !i_rdf;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            shreg <= 8'h00;
            cnt   <= 3'h0;
            act_q <= 1'b0;
            octet <= 8'h00;
            vld   <= 1'b0;
            done  <= 1'b0;
            bad   <= 1'b0;
            flt   <= 1'b0;
        end else begin
            shreg <= next_shreg;
            cnt   <= next_cnt;
            act_q <= next_act_q;
            octet <= next_octet;
            vld   <= next_vld;
            done  <= next_done;
            bad   <= next_bad;
            flt   <= next_flt;
        end
    end

    assign o_octet       = octet;
    assign o_octet_valid = vld;
    assign o_frame_done  = done;
    assign o_frame_bad   = bad;
    assign o_fault       = flt;

    AST_BAD_PARTIAL: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (!i_act && act_q && cnt != 3'h0) |=> (done && bad))
        else $error("partial octet not flagged");
    AST_OCTET_MSB: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_act && i_rxc_fall && cnt == ftl_pkg::BIT_LAST) |=> (vld && octet[0] == $past(i_rdf)))
        else $error("received octet misassembled");
endmodule

// File: design/ftl_top.sv
`timescale 1ns/1ps
// Summary of operation
// - send whole octets, at most 300 per frame
// - octets and bits go most significant first
// - rebuild received octets unchanged, msb first
// - terminal can reset equipment at any time
// - configuration word shifted out to equipment
// - status report may follow configuration
// - loopback and channel enables steer routing; here request needs any tx enable or loopback, activity any rx enable
// - frame runs from start word to end word
// - seven interface signals, fixed directions
// - reset excludes configuration and transmission
// - data low for zero, sampled txc falling
// - request and clear idle low, data high
module ftl_top (
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // avalon-mm slave
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    // equipment link
    input  wire logic        i_transmit_clock,
    input  wire logic        i_clear_to_send,
    input  wire logic        i_receive_clock,
    input  wire logic        i_receive_activity,
    input  wire logic        i_receive_data_framing,
    output logic             o_request_to_send,
    output logic             o_transmit_data
);
    // two flop synchronisers, stage one read only by stage two
    logic [4:0] s1, s2;
    logic       txc_q, rxc_q;
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            s1    <= 5'h01; // idle link levels, no false edge or frame after reset
            s2    <= 5'h01;
            txc_q <= 1'b0;
            rxc_q <= 1'b0;
        end else begin
            s1    <= {i_transmit_clock, i_clear_to_send, i_receive_clock,
                      i_receive_activity, i_receive_data_framing};
            s2    <= s1;
            txc_q <= s2[4];
            rxc_q <= s2[2];
        end
    end
    logic txc_fall, rxc_fall, cts;
    assign txc_fall = txc_q & ~s2[4];
    assign rxc_fall = rxc_q & ~s2[2];
    assign cts      = s2[3];

    // registers and transmit state
    logic [31:0] ctrl, next_ctrl;
    logic [9:0]  txw, next_txw;
    logic        txw_full, next_txw_full;
    ftl_pkg::ftl_tx_state_t st, next_st;
    logic [7:0]  sh, next_sh;
    logic [31:0] cfg_sh, next_cfg_sh;
    logic [5:0]  bitn, next_bitn;
    logic [8:0]  octs, next_octs;
    logic        rts, next_rts, txd, next_txd;
    logic        ovf, next_ovf;
    logic [31:0] rdata, next_rdata;
    logic        rtake, ack, next_ack;
    logic [7:0]  rx_octet;
    logic        rx_vld, rx_done, rx_bad, rx_flt;
    logic        acc;
    assign acc = i_avs_read | i_avs_write;

    always_comb begin
        next_ctrl     = ctrl;
        next_txw      = txw;
        next_txw_full = txw_full;
        next_st       = st;
        next_sh       = sh;
        next_cfg_sh   = cfg_sh;
        next_bitn     = bitn;
        next_octs     = octs;
        next_rts      = rts;
        next_txd      = txd;
        next_ovf      = ovf;
        next_rdata    = rdata;
        next_ack      = acc & ~ack;
        rtake         = 1'b0;
        if (i_avs_write && !ack) begin
            unique case (i_avs_address)
                ftl_pkg::OFS_CTRL:   next_ctrl = i_avs_writedata;
                ftl_pkg::OFS_TXDATA: begin
                    next_txw      = i_avs_writedata[9:0];
                    next_txw_full = 1'b1;
                end
                default: ;
            endcase
        end
        if (i_avs_read && !ack) begin
            unique case (i_avs_address)
                ftl_pkg::OFS_CTRL:   next_rdata = ctrl;
                ftl_pkg::OFS_STATUS: next_rdata = {22'h0, ovf, rx_flt, rx_bad,
                                                   rx_done, rx_vld, txw_full, st, rts};
                ftl_pkg::OFS_RXDATA: begin
                    next_rdata = {24'h0, rx_octet};
                    rtake      = 1'b1;
                end
                default: next_rdata = 32'h0;
            endcase
        end
        unique case (st)
            ftl_pkg::FTL_IDLE: begin
                next_rts = 1'b0;
                next_txd = 1'b1;
                if (ctrl[ftl_pkg::CTRL_RESET]) begin
                    next_st = ftl_pkg::FTL_RESET;
                end else if (ctrl[ftl_pkg::CTRL_CONFIG]) begin
                    next_cfg_sh = ctrl;
                    next_bitn   = 6'h0;
                    next_rts    = 1'b1;
                    next_st     = ftl_pkg::FTL_CFG;
                end else if (txw_full && txw[ftl_pkg::TXD_START]) begin
                    next_txw_full = 1'b0;
                    next_octs     = 9'h0;
                    next_ovf      = 1'b0;
                    next_rts      = 1'b1;
                    next_st       = ftl_pkg::FTL_WAIT;
                end else if (txw_full) begin
                    next_txw_full = 1'b0;
                end
            end
            // reset held on request low, data low, until software releases it
            ftl_pkg::FTL_RESET: begin
                next_rts = 1'b0;
                next_txd = 1'b0;
                if (!ctrl[ftl_pkg::CTRL_RESET]) begin
                    next_txd = 1'b1;
                    next_st  = ftl_pkg::FTL_IDLE;
                end
            end
            ftl_pkg::FTL_CFG: begin
                if (txc_fall && cts) begin
                    next_txd    = cfg_sh[ftl_pkg::CFG_BITS - 1];
                    next_cfg_sh = {cfg_sh[30:0], 1'b0};
                    next_bitn   = bitn + 6'h1;
                    if (bitn == ftl_pkg::CFG_LAST) begin
                        next_ctrl[ftl_pkg::CTRL_CONFIG] = 1'b0;
                        next_st = ftl_pkg::FTL_DONE;
                    end
                end
            end
            ftl_pkg::FTL_WAIT: begin
                if (txw_full && !txw[ftl_pkg::TXD_END] && cts) begin
                    next_sh       = txw[7:0];
                    next_txw_full = 1'b0;
                    next_bitn     = 6'h0;
                    next_st       = ftl_pkg::FTL_DATA;
                    if (octs == ftl_pkg::MAX_OCTETS) begin
                        next_ovf = 1'b1;
                        next_st  = ftl_pkg::FTL_WAIT;
                    end
                end else if (txw_full && txw[ftl_pkg::TXD_END]) begin
                    next_txw_full = 1'b0;
                    next_ovf = ovf | (octs < ftl_pkg::MIN_OCTETS);
                    next_st  = ftl_pkg::FTL_DONE;
                end
            end
            ftl_pkg::FTL_DATA: begin
                // bit changes only on equipment clock, data taken at its falling edge
                if (txc_fall) begin
                    next_txd  = sh[7];
                    next_sh   = {sh[6:0], 1'b0};
                    next_bitn = bitn + 6'h1;
                    if (bitn[2:0] == ftl_pkg::BIT_LAST) begin
                        next_octs = octs + 9'h1;
                        next_st   = ftl_pkg::FTL_WAIT;
                    end
                end
            end
            ftl_pkg::FTL_DONE: begin
                if (txc_fall) begin
                    next_rts = 1'b0;
                    next_txd = 1'b1;
                    next_st  = ftl_pkg::FTL_IDLE;
                end
            end
            default: next_st = ftl_pkg::FTL_IDLE;
        endcase
        // reset pre-empts any other service
        if (ctrl[ftl_pkg::CTRL_RESET] && st != ftl_pkg::FTL_RESET) begin
            next_st  = ftl_pkg::FTL_RESET;
            next_rts = 1'b0;
            next_txd = 1'b0;
        end
    end
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl     <= ftl_pkg::CTRL_RESET_VAL;
            txw      <= 10'h0;
            txw_full <= 1'b0;
            st       <= ftl_pkg::FTL_IDLE;
            sh       <= 8'h00;
            cfg_sh   <= 32'h0;
            bitn     <= 6'h0;
            octs     <= 9'h0;
            rts      <= 1'b0;
            txd      <= 1'b1;
            ovf      <= 1'b0;
            rdata    <= 32'h0;
            ack      <= 1'b0;
        end else begin
            ctrl     <= next_ctrl;
            txw      <= next_txw;
            txw_full <= next_txw_full;
            st       <= next_st;
            sh       <= next_sh;
            cfg_sh   <= next_cfg_sh;
            bitn     <= next_bitn;
            octs     <= next_octs;
            rts      <= next_rts;
            txd      <= next_txd;
            ovf      <= next_ovf;
            rdata    <= next_rdata;
            ack      <= next_ack;
        end
    end

    // receive path open in every state, so a status report can follow configuration
    logic loop_on, rx_act, rx_dat;
    assign loop_on = ctrl[ftl_pkg::CTRL_LOOP_HI] | ctrl[ftl_pkg::CTRL_LOOP_LO];
    assign rx_act  = (|ctrl[ftl_pkg::CTRL_RXEN_HI:ftl_pkg::CTRL_RXEN_LO]) & s2[1];
    assign rx_dat  = s2[0];

    ftl_rx u_rx (
        .i_sys_clk     (i_sys_clk),
        .i_rst         (i_rst),
        .i_rxc_fall    (rxc_fall),
        .i_act         (rx_act),
        .i_rdf         (rx_dat),
        .i_take        (rtake),
        .o_octet       (rx_octet),
        .o_octet_valid (rx_vld),
        .o_frame_done  (rx_done),
        .o_frame_bad   (rx_bad),
        .o_fault       (rx_flt)
    );

    assign o_avs_waitrequest = acc & ~ack;
    assign o_avs_readdata    = rdata;
    // all transmit channels off keeps the medium quiet; loopback still runs
    assign o_request_to_send = rts & ((|ctrl[ftl_pkg::CTRL_TXEN_HI:ftl_pkg::CTRL_TXEN_LO])
                                      | loop_on);
    assign o_transmit_data   = txd;

    sequence seq_reset_req;
        ctrl[ftl_pkg::CTRL_RESET] && st != ftl_pkg::FTL_RESET;
    endsequence
    sequence seq_quiet;
        st == ftl_pkg::FTL_RESET && !rts;
    endsequence
    AST_RESET_PREEMPT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        seq_reset_req |=> seq_quiet)
        else $error("reset did not pre-empt");
    AST_IDLE_LEVELS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (st == ftl_pkg::FTL_IDLE && $past(st) == ftl_pkg::FTL_IDLE) |-> (!rts && txd))
        else $error("idle levels wrong");
    AST_MAX_OCTETS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        octs <= ftl_pkg::MAX_OCTETS)
        else $error("octet limit exceeded");
    AST_PACED: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (st == ftl_pkg::FTL_DATA && !txc_fall && !ctrl[ftl_pkg::CTRL_RESET]) |=> $stable(txd))
        else $error("data changed without clock");
    AST_MSB_FIRST: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (st == ftl_pkg::FTL_DATA && txc_fall && !ctrl[ftl_pkg::CTRL_RESET])
            |=> txd == $past(sh[7]))
        else $error("bit order wrong");
    AST_FRAME_START: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (st == ftl_pkg::FTL_IDLE && $past(st) == ftl_pkg::FTL_IDLE && next_st == ftl_pkg::FTL_WAIT)
            |-> (txw_full && txw[ftl_pkg::TXD_START]))
        else $error("frame began without start word");
endmodule

// File: include/ftl_pkg.sv
package ftl_pkg;
    // register byte offsets
    localparam logic [3:0] OFS_CTRL     = 4'h0;
    localparam logic [3:0] OFS_STATUS   = 4'h4;
    localparam logic [3:0] OFS_TXDATA   = 4'h8;
    localparam logic [3:0] OFS_RXDATA   = 4'hc;
    // control field positions
    localparam int CTRL_RESET    = 0;
    localparam int CTRL_CONFIG   = 1;
    localparam int CTRL_HALF_DPX = 2;
    localparam int CTRL_LOOP_LO  = 3;
    localparam int CTRL_LOOP_HI  = 4;
    localparam int CTRL_PRE_LO   = 8;
    localparam int CTRL_PRE_HI   = 10;
    localparam int CTRL_GAP_LO   = 12;
    localparam int CTRL_GAP_HI   = 14;
    localparam int CTRL_TXEN_LO  = 16;
    localparam int CTRL_TXEN_HI  = 23;
    localparam int CTRL_RXEN_LO  = 24;
    localparam int CTRL_RXEN_HI  = 31;
    // txdata word fields
    localparam int TXD_START = 8;
    localparam int TXD_END   = 9;
    // reset value: full duplex, no loopback, all channels enabled
    localparam logic [31:0] CTRL_RESET_VAL = 32'hffff_0000;
    // limits
    localparam logic [8:0] MAX_OCTETS = 9'h12c;
    localparam logic [8:0] MIN_OCTETS = 9'h003;
    localparam logic [2:0] BIT_LAST   = 3'h7;
    localparam int CFG_BITS = 32;
    localparam logic [5:0] CFG_LAST = 6'h1f;
    typedef enum logic [2:0] {
        FTL_IDLE  = 3'b000,
        FTL_RESET = 3'b001,
        FTL_CFG   = 3'b010,
        FTL_WAIT  = 3'b011,
        FTL_DATA  = 3'b100,
        FTL_DONE  = 3'b101
    } ftl_tx_state_t;
endpackage

// File: testbench/fieldbus_terminal_equipment_link_tb.sv
`timescale 1ns/1ps
module fieldbus_terminal_equipment_link_tb;
    typedef struct {
        logic        wr;
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic [31:0] exp;
        logic [31:0] mask;
    } ftl_row_t;

    logic        i_sys_clk;
    logic        i_rst;
    logic [3:0]  i_avs_address;
    logic        i_avs_read;
    logic        i_avs_write;
    logic [31:0] i_avs_writedata;
    logic [31:0] o_avs_readdata;
    logic        o_avs_waitrequest;
    logic        transmit_clock;
    logic        clear_to_send;
    logic        receive_clock;
    logic        receive_activity;
    logic        receive_data_framing;
    logic        request_to_send;
    logic        transmit_data;
    int          n_errors = 0;
    int          checks_done = 0;
    logic [31:0] rd;
    logic [23:0] win;
    logic        found;
    ftl_row_t    rows[5];

    ftl_top i_ftl_top (
        .i_sys_clk              (i_sys_clk),
        .i_rst                  (i_rst),
        .i_avs_address          (i_avs_address),
        .i_avs_read             (i_avs_read),
        .i_avs_write            (i_avs_write),
        .i_avs_writedata        (i_avs_writedata),
        .o_avs_readdata         (o_avs_readdata),
        .o_avs_waitrequest      (o_avs_waitrequest),
        .i_transmit_clock       (transmit_clock),
        .i_clear_to_send        (clear_to_send),
        .i_receive_clock        (receive_clock),
        .i_receive_activity     (receive_activity),
        .i_receive_data_framing (receive_data_framing),
        .o_request_to_send      (request_to_send),
        .o_transmit_data        (transmit_data)
    );

    ftl_equip_model i_ftl_equip_model (
        .i_request_to_send      (request_to_send),
        .i_transmit_data        (transmit_data),
        .o_transmit_clock       (transmit_clock),
        .o_clear_to_send        (clear_to_send),
        .o_receive_clock        (receive_clock),
        .o_receive_activity     (receive_activity),
        .o_receive_data_framing (receive_data_framing)
    );

    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end

    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // answer latency is the slave's business: wait for waitrequest low
    task automatic bus_wait;
        do @(posedge i_sys_clk); while (o_avs_waitrequest !== 1'b0);
    endtask

    task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= 1'b1;
        bus_wait();
        i_avs_write <= 1'b0;
    endtask

    task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_sys_clk);
        i_avs_address <= a;
        i_avs_read <= 1'b1;
        bus_wait();
        d = o_avs_readdata;
        i_avs_read <= 1'b0;
    endtask

    // polls a register bit; gives up after a bounded number of reads
    task automatic wait_bit(input logic [3:0] a, input int b, input logic val);
        logic [31:0] v;
        for (int k = 0; k < 2000; k++) begin
            bus_read(a, v);
            if (v[b] === val) break;
        end
        check("wait bit", {31'h0, v[b]}, {31'h0, val});
    endtask

    task automatic send_frame(input logic [7:0] o0, input logic [7:0] o1, input int n);
        bus_write(ftl_pkg::OFS_TXDATA, 32'h0000_0100);
        wait_bit(ftl_pkg::OFS_STATUS, 0, 1'b1);
        for (int i = 0; i < n; i++) begin
            wait_bit(ftl_pkg::OFS_STATUS, 4, 1'b0);
            bus_write(ftl_pkg::OFS_TXDATA, {24'h0, (i == 0) ? o0 : (i == 1) ? o1 : 8'h81});
        end
        wait_bit(ftl_pkg::OFS_STATUS, 4, 1'b0);
        bus_write(ftl_pkg::OFS_TXDATA, 32'h0000_0200);
        wait_bit(ftl_pkg::OFS_STATUS, 0, 1'b0);
    endtask

    initial begin
        #1500000;
        n_errors++;
        complete_run();
    end

    initial begin
        i_rst = 1'b1;
        i_avs_address = 4'h0;
        i_avs_read = 1'b0;
        i_avs_write = 1'b0;
        i_avs_writedata = 32'h0;
        rows[0] = '{1'b0, ftl_pkg::OFS_CTRL, 32'h0, ftl_pkg::CTRL_RESET_VAL, 32'hffff_ffff};
        rows[1] = '{1'b0, ftl_pkg::OFS_STATUS, 32'h0, 32'h0, 32'h0000_03ff};
        rows[2] = '{1'b1, ftl_pkg::OFS_CTRL, 32'h0f0f_5314, 32'h0f0f_5314, 32'hffff_771c};
        rows[3] = '{1'b1, 4'h2, 32'hdead_beef, 32'h0, 32'hffff_ffff};
        rows[4] = '{1'b1, ftl_pkg::OFS_CTRL, ftl_pkg::CTRL_RESET_VAL,
                    ftl_pkg::CTRL_RESET_VAL, 32'hffff_ffff};
        repeat (3) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        check("rts idle", {31'h0, request_to_send}, 32'h0);
        check("txd idle", {31'h0, transmit_data}, 32'h1);
        foreach (rows[i]) begin
            if (rows[i].wr) bus_write(rows[i].addr, rows[i].wdata);
            bus_read(rows[i].addr, rd);
            check("register", rd & rows[i].mask, rows[i].exp & rows[i].mask);
        end
        // configuration word goes out, go bit clears itself
        bus_write(ftl_pkg::OFS_CTRL, ftl_pkg::CTRL_RESET_VAL | 32'h2);
        wait_bit(ftl_pkg::OFS_CTRL, ftl_pkg::CTRL_CONFIG, 1'b0);
        // minimum frame of three octets, bit stream searched for the pattern
        i_ftl_equip_model.tx_bits.delete();
        send_frame(8'ha5, 8'h3c, 3);
        check("txd after end", {31'h0, transmit_data}, 32'h1);
        found = 1'b0;
        for (int i = 0; i + 24 <= i_ftl_equip_model.tx_bits.size(); i++) begin
            for (int j = 0; j < 24; j++) win = {win[22:0], i_ftl_equip_model.tx_bits[i + j]};
            if (win === 24'ha53c81) found = 1'b1;
        end
        check("tx stream", {31'h0, found}, 32'h1);
        bus_read(ftl_pkg::OFS_STATUS, rd);
        check("three octets ok", {31'h0, rd[9]}, 32'h0);
        // receive two octets, read each as it arrives
        fork
            i_ftl_equip_model.send_bits(32'h5ac3, 16);
            begin
                wait_bit(ftl_pkg::OFS_STATUS, 5, 1'b1);
                bus_read(ftl_pkg::OFS_RXDATA, rd);
                check("rx octet 0", {24'h0, rd[7:0]}, 32'h5a);
                wait_bit(ftl_pkg::OFS_STATUS, 5, 1'b1);
                bus_read(ftl_pkg::OFS_RXDATA, rd);
                check("rx octet 1", {24'h0, rd[7:0]}, 32'hc3);
            end
        join
        repeat (20) @(posedge i_sys_clk);
        bus_read(ftl_pkg::OFS_STATUS, rd);
        check("frame good", {30'h0, rd[7:6]}, 32'h1);
        // eleven bits: one octet and a misaligned tail
        fork
            i_ftl_equip_model.send_bits(32'h0000_02d3, 11);
            begin
                wait_bit(ftl_pkg::OFS_STATUS, 5, 1'b1);
                bus_read(ftl_pkg::OFS_RXDATA, rd);
                check("rx octet 2", {24'h0, rd[7:0]}, 32'h5a);
            end
        join
        repeat (20) @(posedge i_sys_clk);
        bus_read(ftl_pkg::OFS_STATUS, rd);
        check("frame bad", {31'h0, rd[7]}, 32'h1);
        i_ftl_equip_model.set_fault(1'b1);
        wait_bit(ftl_pkg::OFS_STATUS, 8, 1'b1);
        i_ftl_equip_model.set_fault(1'b0);
        wait_bit(ftl_pkg::OFS_STATUS, 8, 1'b0);
        // all transmit channels off: frame runs inside but the request pin stays low
        bus_write(ftl_pkg::OFS_CTRL, 32'hff00_0000);
        bus_write(ftl_pkg::OFS_TXDATA, 32'h0000_0100);
        wait_bit(ftl_pkg::OFS_STATUS, 0, 1'b1);
        check("rts gated", {31'h0, request_to_send}, 32'h0);
        bus_write(ftl_pkg::OFS_CTRL, ftl_pkg::CTRL_RESET_VAL);
        check("rts enabled", {31'h0, request_to_send}, 32'h1);
        // reset service pre-empts a running transmission
        bus_write(ftl_pkg::OFS_CTRL, ftl_pkg::CTRL_RESET_VAL | 32'h1);
        repeat (10) @(posedge i_sys_clk);
        check("reset rts", {31'h0, request_to_send}, 32'h0);
        check("reset txd", {31'h0, transmit_data}, 32'h0);
        bus_write(ftl_pkg::OFS_CTRL, ftl_pkg::CTRL_RESET_VAL);
        repeat (10) @(posedge i_sys_clk);
        check("txd released", {31'h0, transmit_data}, 32'h1);
        // two octets is too short a frame
        send_frame(8'h11, 8'h22, 2);
        bus_read(ftl_pkg::OFS_STATUS, rd);
        check("short frame", {31'h0, rd[9]}, 32'h1);
        complete_run();
    end
endmodule

// File: testbench/ftl_equip_model.sv
`timescale 1ns/1ps
module ftl_equip_model (
    // from terminal
    input  wire logic i_request_to_send,
    input  wire logic i_transmit_data,
    // to terminal
    output logic      o_transmit_clock,
    output logic      o_clear_to_send,
    output logic      o_receive_clock,
    output logic      o_receive_activity,
    output logic      o_receive_data_framing
);
    logic tx_bits[$];
    logic fault_on;

    // transmit clock runs free, the terminal must follow it
    initial begin
        o_transmit_clock = 1'b0;
        o_clear_to_send = 1'b0;
        o_receive_clock = 1'b0;
        o_receive_activity = 1'b0;
        o_receive_data_framing = 1'b1;
        fault_on = 1'b0;
        forever #100 o_transmit_clock = ~o_transmit_clock;
    end

    // clear follows request one rising edge late; request low (reset service) drops it
    always @(posedge o_transmit_clock) begin
        o_clear_to_send <= i_request_to_send;
    end

    // data taken at the falling edge only while both handshake lines are up
    always @(negedge o_transmit_clock) begin
        if (i_request_to_send && o_clear_to_send) begin
            tx_bits.push_back(i_transmit_data);
        end
    end

    // receive clock only moves inside a frame; offset keeps edges off the system clock
    // activity only for frames sent here, never an echo of the terminal's own data
    task automatic send_bits(input logic [31:0] word, input int nbits);
        #5;
        o_receive_activity = 1'b1;
        for (int i = nbits - 1; i >= 0; i--) begin
            o_receive_data_framing = word[i];
            #50 o_receive_clock = 1'b1;
            #100 o_receive_clock = 1'b0;
            #50;
        end
        o_receive_activity = 1'b0;
        o_receive_data_framing = ~fault_on;
    endtask

    // fault shown as data low while activity is low, no detail
    task automatic set_fault(input logic on);
        #5;
        fault_on = on;
        o_receive_data_framing = ~on;
    endtask
endmodule
